// >>> design/smm_mapper.sv
// Function
// RULE1: Double-rate mode runs the internal sample clock at twice the base rate (88.2 or 96 kHz).
// RULE2: Samples stay 24 bits wide in double-rate and quad-rate modes, as at base rate.
// RULE3: A channel split over two slots puts odd samples in the first slot, even in the second.
// RULE4: Slot multiplexing turns on by itself whenever a high-rate mode is active.
// RULE5: Double rate maps inputs 1-4 to pairs 1/2..7/8 of port one, inputs 5-8 likewise on port two.
// RULE6: In double rate the ports still send frames at the 44.1 or 48 kHz base rate.
// RULE7: Quad rate spreads each channel over four slots, inputs 1-2 on port one, 3-4 on port two.
// RULE8: In quad rate inputs 5-8 reach no slot and each port carries only two channels.
// RULE9: In quad rate the ports still send frames at the 44.1 or 48 kHz base rate.
// RULE10: The receiver rebuilds each channel from its slot group in ascending slot order.
`timescale 1ns/10ps
module smm_mapper
	import smm_pkg::*;
#(
	parameter int W     = SAMPLE_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic                  CLK_I,
	input  wire logic                  RESET_N_I,
	input  wire logic                  DOUBLE_RATE_MODE_I,
	input  wire logic                  QUAD_RATE_MODE_I,
	input  wire logic                  BASE_48K_I,
	input  wire logic [CHANNELS*W-1:0] IN_DATA_I,
	input  wire logic                  IN_VALID_I,
	output logic                       IN_READY_O,
	output logic [SLOTS*W-1:0]         OPTICAL_PORT_FIRST_O,
	output logic [SLOTS*W-1:0]         OPTICAL_PORT_SECOND_O,
	output logic                       FRAME_STROBE_O,
	output logic                       SAMPLE_TICK_O,
	output logic                       SLOT_SAMPLE_MULTIPLEXING_O,
	output logic                       UNDERRUN_O,
	output logic                       FIFO_FULL_O
);
	// ************************************************************
	// Input buffer
	// ************************************************************
	smm_stream_if #(.W(CHANNELS*W)) in_if ();
	smm_stream_if #(.W(CHANNELS*W)) q_if ();

	assign in_if.valid = IN_VALID_I;
	assign in_if.data  = IN_DATA_I;
	assign IN_READY_O  = in_if.ready;

	smm_fifo #(
		.W     (CHANNELS*W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_i   (CLK_I),
		.rst_n_i (RESET_N_I),
		.wr      (in_if.snk),
		.rd      (q_if.src),
		.full_o  (FIFO_FULL_O)
	);

	// ************************************************************
	// Mode selection, applied only between frames
	// ************************************************************
	smm_mode_e          mode;
	logic [PHASE_W-1:0] phase;
	logic               tick;
	logic [2:0]         mult;

	wire smm_mode_e req_mode = QUAD_RATE_MODE_I   ? SMM_QUAD :
	                           DOUBLE_RATE_MODE_I ? SMM_DOUBLE : SMM_SINGLE;
	wire            mode_ld  = (phase == PHASE_RESET) && !tick;

	always_comb begin
		case (mode)
			SMM_DOUBLE: mult = MULT_DOUBLE;
			SMM_QUAD:   mult = MULT_QUAD;
			default:    mult = MULT_SINGLE;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			mode <= MODE_RESET;
		end else if (mode_ld) begin
			mode <= req_mode;
		end
	end

	assign SLOT_SAMPLE_MULTIPLEXING_O = (mode != SMM_SINGLE); // RULE4

	// ************************************************************
	// Internal sample clock and slot phase
	// ************************************************************
	smm_rate_gen u_rate (
		.clk_i      (CLK_I),
		.rst_n_i    (RESET_N_I),
		.base_48k_i (BASE_48K_I),
		.mult_i     (mult), // RULE1
		.tick_o     (tick)
	);

	wire [PHASE_W-1:0] last_phase = PHASE_W'(mult - 3'h1);
	wire               frame_now  = tick && (phase == last_phase); // RULE6 RULE9

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			phase          <= PHASE_RESET;
			FRAME_STROBE_O <= 1'b0;
			UNDERRUN_O     <= 1'b0;
		end else begin
			if (tick) begin
				phase <= frame_now ? PHASE_RESET : phase + 1'b1;
			end
			FRAME_STROBE_O <= frame_now;
			UNDERRUN_O     <= tick && !q_if.valid;
		end
	end

	assign SAMPLE_TICK_O = tick;
	assign q_if.ready    = tick;

	// ************************************************************
	// Sample split and slot assembly
	// ************************************************************
	wire [CHANNELS*W-1:0] smp = q_if.valid ? q_if.data : '0;
	logic [W-1:0]         ch      [CHANNELS];
	logic [W-1:0]         asm_q   [PORTS][SLOTS];
	logic [W-1:0]         out_q   [PORTS][SLOTS];

	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		assign ch[c] = smp[c*W +: W]; // RULE2
	end

	for (genvar p = 0; p < PORTS; p++) begin : g_port
		for (genvar s = 0; s < SLOTS; s++) begin : g_slot
			localparam int DBL_SRC  = 4 * p + s / 2;
			localparam int QUAD_SRC = 2 * p + s / 4;
			localparam int DBL_PH   = s % 2;
			localparam int QUAD_PH  = s % 4;

			// Ascending slots take successive samples, first sample first
			wire dbl_hit  = (phase == PHASE_W'(DBL_PH)); // RULE3 RULE10
			wire quad_hit = (phase == PHASE_W'(QUAD_PH)); // RULE10
			wire hit      = tick && ((mode == SMM_DOUBLE) ? dbl_hit :
			                         (mode == SMM_QUAD)   ? quad_hit : 1'b1);
			wire [W-1:0] val = (mode == SMM_DOUBLE) ? ch[DBL_SRC] : // RULE5
			                   (mode == SMM_QUAD)   ? ch[QUAD_SRC] : // RULE7 RULE8
			                   ch[s];
			wire [W-1:0] next_slot = hit ? val : asm_q[p][s];

			always_ff @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					asm_q[p][s] <= '0;
					out_q[p][s] <= '0;
				end else begin
					asm_q[p][s] <= next_slot;
					if (frame_now) begin
						out_q[p][s] <= next_slot;
					end
				end
			end

			if (p == 0) begin : g_first
				assign OPTICAL_PORT_FIRST_O[s*W +: W] = out_q[p][s];
			end else begin : g_second
				assign OPTICAL_PORT_SECOND_O[s*W +: W] = out_q[p][s];
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	// Gap between sample ticks under unchanged settings
	logic [12:0] gap;
	logic        steady;
	logic        base_q;
	smm_mode_e   mode_q;
	int          exp_gap;

	always_comb begin
		exp_gap = CLK_HZ / ((BASE_48K_I ? BASE_48K_HZ : BASE_44K1_HZ) * int'(mult));
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			gap    <= '0;
			steady <= 1'b0;
			base_q <= 1'b0;
			mode_q <= MODE_RESET;
		end else begin
			gap    <= tick ? '0 : gap + 1'b1;
			base_q <= BASE_48K_I;
			mode_q <= mode;
			if ((base_q != BASE_48K_I) || (mode_q != mode)) begin
				steady <= 1'b0;
			end else if (tick) begin
				steady <= 1'b1;
			end
		end
	end

	property p_tick_gap;
		tick && steady && (base_q == BASE_48K_I) && (mode_q == mode)
			|-> (int'(gap) + 1 >= exp_gap) && (int'(gap) <= exp_gap);
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("sample tick spacing wrong"); // RULE1

	property p_width;
		(tick && mode == SMM_SINGLE) |=> out_q[0][0] == $past(ch[0]);
	endproperty
	a_width: assert property (p_width) else $error("single-rate slot lost sample bits"); // RULE2

	property p_odd_first;
		(tick && mode == SMM_DOUBLE && phase == 2'h0) |=> asm_q[0][0] == $past(ch[0]);
	endproperty
	a_odd_first: assert property (p_odd_first) else $error("odd sample not in first slot"); // RULE3

	property p_auto_mux;
		(mode_ld && (req_mode != SMM_SINGLE)) |=> SLOT_SAMPLE_MULTIPLEXING_O;
	endproperty
	a_auto_mux: assert property (p_auto_mux) else $error("multiplexing off in high rate"); // RULE4

	property p_dbl_map;
		(tick && mode == SMM_DOUBLE && phase == 2'h1)
			|=> (out_q[0][1] == $past(ch[0])) && (out_q[1][7] == $past(ch[7]));
	endproperty
	a_dbl_map: assert property (p_dbl_map) else $error("double-rate slot map wrong"); // RULE5

	property p_dbl_frame;
		(tick && mode == SMM_DOUBLE && phase == 2'h0) |=> !FRAME_STROBE_O ##1 !FRAME_STROBE_O;
	endproperty
	a_dbl_frame: assert property (p_dbl_frame) else $error("double-rate frame too early"); // RULE6

	property p_quad_map;
		(tick && mode == SMM_QUAD && phase == 2'h3)
			|=> (out_q[0][3] == $past(ch[0])) && (out_q[1][7] == $past(ch[3]));
	endproperty
	a_quad_map: assert property (p_quad_map) else $error("quad-rate slot map wrong"); // RULE7

	property p_quad_drop;
		(tick && mode == SMM_QUAD && phase == 2'h3)
			|=> (out_q[0][7] == $past(ch[1])) && (out_q[1][3] == $past(ch[2]));
	endproperty
	a_quad_drop: assert property (p_quad_drop) else $error("quad-rate upper input reached a slot"); // RULE8

	property p_quad_frame;
		(tick && mode == SMM_QUAD && phase == 2'h3) |=> FRAME_STROBE_O && (phase == 2'h0);
	endproperty
	a_quad_frame: assert property (p_quad_frame) else $error("quad-rate frame missing"); // RULE9

	c_dbl_frame: cover property (FRAME_STROBE_O && mode == SMM_DOUBLE);
	c_quad_frame: cover property (FRAME_STROBE_O && mode == SMM_QUAD);
	c_underrun: cover property (UNDERRUN_O);
	c_full:     cover property (FIFO_FULL_O && IN_VALID_I);

endmodule

// >>> design/smm_pkg.sv
package smm_pkg;

	// ************************************************************
	// Clock and rates
	// ************************************************************
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
	localparam int          BASE_44K1_HZ  = 44100;
	localparam int          BASE_48K_HZ   = 48000;
	localparam int          ACC_W         = 28;

	// ************************************************************
	// Data path shape
	// ************************************************************
	localparam int          SAMPLE_W   = 24;
	localparam int          CHANNELS   = 8;
	localparam int          SLOTS      = 8;
	localparam int          PORTS      = 2;
	localparam int          FIFO_DEPTH = 16;
	localparam int          PHASE_W    = 2;

	// ************************************************************
	// Modes and reset values
	// ************************************************************
	typedef enum logic [1:0] {
		SMM_SINGLE = 2'b00,
		SMM_DOUBLE = 2'b01,
		SMM_QUAD   = 2'b10
	} smm_mode_e;

	localparam logic [2:0]         MULT_SINGLE = 3'h1;
	localparam logic [2:0]         MULT_DOUBLE = 3'h2;
	localparam logic [2:0]         MULT_QUAD   = 3'h4;
	localparam smm_mode_e          MODE_RESET  = SMM_SINGLE;
	localparam logic [PHASE_W-1:0] PHASE_RESET = 2'h0;
	localparam logic [ACC_W-1:0]   ACC_RESET   = 28'h0;

endpackage

// >>> design/smm_stream_if.sv
`timescale 1ns/10ps
interface smm_stream_if #(
	parameter int W = 192
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// >>> design/smm_fifo.sv
`timescale 1ns/10ps
module smm_fifo
	import smm_pkg::*;
#(
	parameter int W     = 192,
	parameter int DEPTH = 16
) (
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	smm_stream_if.snk   wr,
	smm_stream_if.src   rd,
	output logic        full_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wp;
	logic [AW:0]  rp;
	wire          empty = (wp == rp);
	wire          full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
	wire          push  = wr.valid && !full;
	wire          pop   = rd.ready && !empty;

	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem[rp[AW-1:0]];
	assign full_o   = full;

	// ************************************************************
	// Storage and pointers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp[AW-1:0]] <= wr.data;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp <= '0;
			rp <= '0;
		end else begin
			wp <= push ? wp + 1'b1 : wp;
			rp <= pop ? rp + 1'b1 : rp;
		end
	end

endmodule

// >>> design/smm_rate_gen.sv
`timescale 1ns/10ps
module smm_rate_gen
	import smm_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       base_48k_i,
	input  wire logic [2:0] mult_i,
	output logic            tick_o
);
	// ************************************************************
	// Fractional divider: adds the rate each cycle, wraps at CLK_HZ
	// ************************************************************
	logic [ACC_W-1:0] acc;
	wire  [ACC_W-1:0] base_hz = base_48k_i ? ACC_W'(BASE_48K_HZ) : ACC_W'(BASE_44K1_HZ);
	wire  [ACC_W-1:0] rate_hz = base_hz * ACC_W'(mult_i);
	wire  [ACC_W-1:0] sum     = acc + rate_hz;
	wire              wrap    = (sum >= ACC_W'(CLK_HZ));
	wire  [ACC_W-1:0] next_acc = wrap ? sum - ACC_W'(CLK_HZ) : sum;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc    <= ACC_RESET;
			tick_o <= 1'b0;
		end else begin
			acc    <= next_acc;
			tick_o <= wrap;
		end
	end

endmodule

// >>> verification/smm_slot_receiver.sv
`timescale 1ns/10ps
module smm_slot_receiver
	import smm_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic [2:0]                mult_i,
	input  wire logic                      strobe_i,
	input  wire logic [SLOTS*SAMPLE_W-1:0] port_first_i,
	input  wire logic [SLOTS*SAMPLE_W-1:0] port_second_i,
	output logic      [SAMPLE_W-1:0]       chan_o [CHANNELS][4]
);
	wire logic [SLOTS*SAMPLE_W-1:0] port_word [PORTS];

	assign port_word[0] = port_first_i;
	assign port_word[1] = port_second_i;

	// ************************************************************
	// Slot groups back to channels, earliest sample in lowest slot
	// ************************************************************
	always @(posedge clk_i) begin
		if (strobe_i) begin
			for (int p = 0; p < PORTS; p++) begin
				for (int s = 0; s < SLOTS; s++) begin
					if (mult_i != 3'h1 || p == 0) begin
						chan_o[p * (SLOTS / int'(mult_i)) + s / int'(mult_i)][s % int'(mult_i)] <=
							port_word[p][s*SAMPLE_W +: SAMPLE_W];
					end
				end
			end
		end
	end
endmodule

// >>> verification/tb_sample_multiplex_mapper.sv
`timescale 1ns/10ps
module tb_sample_multiplex_mapper;
	import smm_pkg::*;
	logic                         CLK_I;
	logic                         RESET_N_I;
	logic                         DOUBLE_RATE_MODE_I;
	logic                         QUAD_RATE_MODE_I;
	logic                         BASE_48K_I;
	logic [CHANNELS*SAMPLE_W-1:0] IN_DATA_I;
	logic                         IN_VALID_I;
	logic                         IN_READY_O;
	logic [SLOTS*SAMPLE_W-1:0]    OPTICAL_PORT_FIRST_O;
	logic [SLOTS*SAMPLE_W-1:0]    OPTICAL_PORT_SECOND_O;
	logic                         FRAME_STROBE_O;
	logic                         SAMPLE_TICK_O;
	logic                         SLOT_SAMPLE_MULTIPLEXING_O;
	logic                         UNDERRUN_O;
	logic                         FIFO_FULL_O;
	logic [2:0]                   mult;
	logic [SAMPLE_W-1:0]          chan [CHANNELS][4];
	int                           bad_count;
	int                           checked;

	smm_mapper #(.W(SAMPLE_W), .DEPTH(FIFO_DEPTH)) smm_mapper_i (
		.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .DOUBLE_RATE_MODE_I(DOUBLE_RATE_MODE_I),
		.QUAD_RATE_MODE_I(QUAD_RATE_MODE_I), .BASE_48K_I(BASE_48K_I), .IN_DATA_I(IN_DATA_I),
		.IN_VALID_I(IN_VALID_I), .IN_READY_O(IN_READY_O),
		.OPTICAL_PORT_FIRST_O(OPTICAL_PORT_FIRST_O), .OPTICAL_PORT_SECOND_O(OPTICAL_PORT_SECOND_O),
		.FRAME_STROBE_O(FRAME_STROBE_O), .SAMPLE_TICK_O(SAMPLE_TICK_O),
		.SLOT_SAMPLE_MULTIPLEXING_O(SLOT_SAMPLE_MULTIPLEXING_O), .UNDERRUN_O(UNDERRUN_O),
		.FIFO_FULL_O(FIFO_FULL_O));

	smm_slot_receiver smm_slot_receiver_i (
		.clk_i(CLK_I), .mult_i(mult), .strobe_i(FRAME_STROBE_O),
		.port_first_i(OPTICAL_PORT_FIRST_O), .port_second_i(OPTICAL_PORT_SECOND_O), .chan_o(chan));

	initial begin
		CLK_I = 1'b0;
		forever #4 CLK_I = ~CLK_I;
	end

	// ************************************************************
	// Shared helpers
	// ************************************************************
	task automatic check(input string what, input logic [SAMPLE_W-1:0] seen,
		input logic [SAMPLE_W-1:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [SAMPLE_W-1:0] sval(input int c, input int n);
		return {4'(c), 4'(n), 16'h5a3c};
	endfunction

	task automatic wait_evt(input bit strobe, output int n);
		n = 0;
		do begin
			@(negedge CLK_I);
			n++;
		end while (((strobe ? FRAME_STROBE_O : SAMPLE_TICK_O) !== 1'b1) && n < 4000);
		if (n >= 4000) check("event wait", 24'h1, 24'h0);
	endtask

	task automatic push(input int n);
		for (int k = 0; k < n; k++) begin
			IN_VALID_I = 1'b1;
			for (int c = 0; c < CHANNELS; c++) IN_DATA_I[c*SAMPLE_W +: SAMPLE_W] = sval(c, k);
			while (IN_READY_O !== 1'b1) @(negedge CLK_I);
			@(negedge CLK_I);
		end
		IN_VALID_I = 1'b0;
	endtask

	task automatic run_mode(input bit dbl, input bit quad, input bit b48, input int m,
		input int tick_lo, input int frame_lo);
		int n;
		DOUBLE_RATE_MODE_I = dbl;
		QUAD_RATE_MODE_I = quad;
		BASE_48K_I = b48;
		mult = 3'(m);
		wait_evt(1, n);
		wait_evt(1, n);
		check("multiplexing flag", 24'(SLOT_SAMPLE_MULTIPLEXING_O), 24'h1);
		push(m);
		wait_evt(1, n);
		@(negedge CLK_I);
		for (int c = 0; c < SLOTS * PORTS / m; c++) begin
			for (int j = 0; j < m; j++) check("rebuilt sample", chan[c][j], sval(c, j));
		end
		wait_evt(0, n);
		wait_evt(0, n);
		check("tick gap", 24'(n == tick_lo || n == tick_lo + 1), 24'h1);
		wait_evt(1, n);
		wait_evt(1, n);
		check("frame gap", 24'(n == frame_lo || n == frame_lo + 1), 24'h1);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic test_reset();
		int n;
		check("ready after reset", 24'(IN_READY_O), 24'h1);
		check("ports after reset", 24'(|{OPTICAL_PORT_FIRST_O, OPTICAL_PORT_SECOND_O}), 24'h0);
		check("flag after reset", 24'(SLOT_SAMPLE_MULTIPLEXING_O), 24'h0);
		wait_evt(0, n);
		@(negedge CLK_I);
		check("underrun pulse", 24'(UNDERRUN_O), 24'h1);
	endtask

	task automatic test_double();
		run_mode(1'b1, 1'b0, 1'b1, 2, 1302, 2604);
	endtask

	task automatic test_quad();
		run_mode(1'b0, 1'b1, 1'b0, 4, 708, 2834);
	endtask

	task automatic test_fill();
		int n;
		DOUBLE_RATE_MODE_I = 1'b0;
		QUAD_RATE_MODE_I = 1'b0;
		mult = 3'h1;
		wait_evt(1, n);
		wait_evt(1, n);
		check("flag in single", 24'(SLOT_SAMPLE_MULTIPLEXING_O), 24'h0);
		push(FIFO_DEPTH);
		IN_VALID_I = 1'b1;
		repeat (3) begin
			@(negedge CLK_I);
			check("full flag", 24'(FIFO_FULL_O), 24'h1);
			check("ready when full", 24'(IN_READY_O), 24'h0);
		end
		wait_evt(0, n);
		check("full at tick", 24'(FIFO_FULL_O), 24'h1);
		@(negedge CLK_I);
		check("ready after pop", 24'(IN_READY_O), 24'h1);
		check("single frame strobe", 24'(FRAME_STROBE_O), 24'h1);
		IN_VALID_I = 1'b0;
		@(negedge CLK_I);
		for (int s = 0; s < SLOTS; s++) check("single slot", chan[s][0], sval(s, 0));
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		bad_count = 0;
		checked = 0;
		RESET_N_I = 1'b0;
		DOUBLE_RATE_MODE_I = 1'b0;
		QUAD_RATE_MODE_I = 1'b0;
		BASE_48K_I = 1'b0;
		IN_VALID_I = 1'b0;
		IN_DATA_I = '0;
		mult = 3'h1;
		repeat (16) @(posedge CLK_I);
		@(negedge CLK_I);
		RESET_N_I = 1'b1;
		test_reset();
		test_double();
		test_quad();
		test_fill();
		tally_and_finish();
	end

	// Run should end near 40k cycles; this cuts a hang at 100k
	initial begin
		#800000;
		bad_count++;
		tally_and_finish();
	end
endmodule
